/* File: hw/host_link_consts.vh */
// Purpose: timing constants for the smart-converter host link controller
// Assumes: ref_clk at 125 MHz (8 ns)
// Notes: counts derived from printed times, least times rounded up
`ifndef HOST_LINK_CONSTS_VH
`define HOST_LINK_CONSTS_VH
`define CLK_PERIOD_PS 8000
`define T_BUF_PS 500000
`define T_HDSTA_PS 260000
`define T_LOW_PS 500000
`define T_HIGH_PS 260000
`define T_UPD_WAIT_PS 2000000
`define T_FRAME2LOAD_PS 1000000
`define T_LOAD_LOW_PS 2000000
`define T_SPI_WR_HALF_PS 10000
`define T_RD_SLOW_HALF_PS 400000
`define T_RD_FAST_HALF_PS 200000
`define CYC(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CNT_W 10
`define ST_IDLE 4'h0
`define ST_I2C_START 4'h1
`define ST_I2C_BIT 4'h2
`define ST_I2C_STOP 4'h3
`define ST_SPI_SEL 4'h4
`define ST_SPI_BIT 4'h5
`define ST_SPI_END 4'h6
`define ST_GAP 4'h7
`define ST_LOAD 4'h8
`define ST_LOAD_HOLD 4'h9
`define PROTO_I2C 1'b0
`define PROTO_SPI 1'b1
`endif

/* File: hw/host_link_ctrl.v */
// Purpose: host controller driving a smart converter over I2C or SPI, plus load strobe
// Assumes: one clock, link clock generated here by counting ref_clk cycles
// Notes: one frame per request; frame length is a request field
`include "host_link_consts.vh"

module host_link_ctrl #(
  parameter NBITS = 32,
  parameter NCH = 2
) (
  input wire ref_clk,
  input wire rstn,
  input wire req_valid,
  output wire req_ready,
  input wire req_proto,
  input wire req_read,
  input wire req_bcast,
  input wire req_load,
  input wire [NCH-1:0] req_chan,
  input wire [5:0] req_len,
  input wire [NBITS-1:0] req_data,
  input wire fast_readout_select,
  output reg [NBITS-1:0] rsp_data_q,
  output reg rsp_valid_q,
  output reg scl_o_q,
  output reg scl_oe_q,
  input wire sda_i,
  output reg sda_o_q,
  output reg sda_oe_q,
  output reg sclk_q,
  output reg mosi_q,
  output reg sync_n_q,
  input wire miso,
  output reg output_load_strobe_n_q
);
  localparam C_BUF = `CYC(`T_BUF_PS);
  localparam C_HDSTA = `CYC(`T_HDSTA_PS);
  localparam C_LOW = `CYC(`T_LOW_PS);
  localparam C_HIGH = `CYC(`T_HIGH_PS);
  localparam C_WAIT = `CYC(`T_UPD_WAIT_PS);
  localparam C_F2L = `CYC(`T_FRAME2LOAD_PS);
  localparam C_LDW = `CYC(`T_LOAD_LOW_PS);
  localparam C_WR = `CYC(`T_SPI_WR_HALF_PS);
  localparam C_RDS = `CYC(`T_RD_SLOW_HALF_PS);
  localparam C_RDF = `CYC(`T_RD_FAST_HALF_PS);

  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  reg [1:0] rst_sync_q;
  reg [1:0] sda_sync_q;
  reg [1:0] miso_sync_q;
  wire rst_n = rst_sync_q[1];
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync_q <= 2'h3;
      miso_sync_q <= 2'h0;
    end else begin
      sda_sync_q <= {sda_sync_q[0], sda_i};
      miso_sync_q <= {miso_sync_q[0], miso};
    end
  end

  // ----------------------------------------
  // Per-channel update spacing
  // ----------------------------------------
  reg [`CNT_W-1:0] ch_wait_q [0:NCH-1];
  reg [`CNT_W-1:0] bc_wait_q;
  reg [3:0] st_q;
  reg upd_pulse_q;
  reg upd_bc_q;
  reg [NCH-1:0] upd_ch_q;

  function chan_busy;
    input [NCH-1:0] sel;
    integer k;
    begin
      chan_busy = 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        if (sel[k] && ch_wait_q[k] != {`CNT_W{1'b0}}) begin
          chan_busy = 1'b1;
        end
      end
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_chw
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          ch_wait_q[g] <= {`CNT_W{1'b0}};
        end else if (upd_pulse_q && (upd_ch_q[g] || upd_bc_q)) begin
          ch_wait_q[g] <= C_WAIT[`CNT_W-1:0];
        end else if (ch_wait_q[g] != {`CNT_W{1'b0}}) begin
          ch_wait_q[g] <= ch_wait_q[g] - 1'b1;
        end
      end
    end
  endgenerate

  wire bc_busy = bc_wait_q != {`CNT_W{1'b0}};
  wire write_req = !req_read && !req_load;
  wire spacing_ok = !write_req || (!bc_busy &&
    (req_bcast ? !chan_busy({NCH{1'b1}}) : !chan_busy(req_chan)));
  // the first frame fixes the protocol; mismatches are held off
  reg proto_set_q;
  reg proto_q;
  wire proto_ok = req_load || !proto_set_q || (req_proto == proto_q);
  // The spacing counters load one cycle after the answer, so hold off that cycle too
  assign req_ready = (st_q == `ST_IDLE) && !upd_pulse_q && spacing_ok && proto_ok;

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  reg [`CNT_W-1:0] cnt_q;
  reg [5:0] bit_q;
  reg [1:0] ph_q;
  reg [NBITS-1:0] sh_q;
  reg rd_q;
  reg after_frame_q;
  wire [`CNT_W-1:0] spi_half = !rd_q ? C_WR[`CNT_W-1:0] :
    (fast_readout_select ? C_RDF[`CNT_W-1:0] : C_RDS[`CNT_W-1:0]);
  wire cnt_zero = cnt_q == {`CNT_W{1'b0}};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= `ST_IDLE;
      cnt_q <= {`CNT_W{1'b0}};
      bit_q <= 6'h0;
      ph_q <= 2'h0;
      sh_q <= {NBITS{1'b0}};
      rd_q <= 1'b0;
      proto_set_q <= 1'b0;
      proto_q <= `PROTO_I2C;
      after_frame_q <= 1'b0;
      bc_wait_q <= {`CNT_W{1'b0}};
      upd_pulse_q <= 1'b0;
      upd_bc_q <= 1'b0;
      upd_ch_q <= {NCH{1'b0}};
      rsp_data_q <= {NBITS{1'b0}};
      rsp_valid_q <= 1'b0;
      scl_o_q <= 1'b1;
      scl_oe_q <= 1'b0;
      sda_o_q <= 1'b1;
      sda_oe_q <= 1'b0;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      sync_n_q <= 1'b1;
      output_load_strobe_n_q <= 1'b1;
    end else begin
      upd_pulse_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      if (!cnt_zero) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (upd_pulse_q && upd_bc_q) begin
        bc_wait_q <= C_WAIT[`CNT_W-1:0];
      end else if (bc_busy) begin
        bc_wait_q <= bc_wait_q - 1'b1;
      end
      case (st_q)
        `ST_IDLE: begin
          if (req_valid && req_ready) begin
            sh_q <= req_data;
            bit_q <= req_len;
            rd_q <= req_read;
            upd_bc_q <= req_bcast;
            upd_ch_q <= req_chan;
            if (req_load) begin
              cnt_q <= after_frame_q ? C_F2L[`CNT_W-1:0] : {`CNT_W{1'b0}};
              st_q <= `ST_LOAD;
            end else begin
              proto_set_q <= 1'b1;
              proto_q <= req_proto;
              if (req_proto == `PROTO_SPI) begin
                sync_n_q <= 1'b0;
                cnt_q <= spi_half;
                st_q <= `ST_SPI_SEL;
              end else begin
                scl_oe_q <= 1'b1;
                sda_oe_q <= 1'b1;
                sda_o_q <= 1'b0;
                cnt_q <= C_HDSTA[`CNT_W-1:0];
                st_q <= `ST_I2C_START;
              end
            end
          end
        end
        `ST_I2C_START: begin
          if (cnt_zero) begin
            scl_o_q <= 1'b0;
            ph_q <= 2'h0;
            cnt_q <= C_LOW[`CNT_W-1:0];
            st_q <= `ST_I2C_BIT;
          end
        end
        `ST_I2C_BIT: begin
          if (cnt_zero) begin
            if (ph_q == 2'h0) begin
              // Low phase ends: data was set at its start, clock rises
              scl_o_q <= 1'b1;
              ph_q <= 2'h1;
              cnt_q <= C_HIGH[`CNT_W-1:0];
            end else begin
              sh_q <= {sh_q[NBITS-2:0], sda_sync_q[1]};
              scl_o_q <= 1'b0;
              ph_q <= 2'h0;
              cnt_q <= C_LOW[`CNT_W-1:0];
              bit_q <= bit_q - 6'h1;
              if (bit_q == 6'h1) begin
                sda_oe_q <= 1'b1;
                sda_o_q <= 1'b0;
                st_q <= `ST_I2C_STOP;
              end
            end
          end else if (ph_q == 2'h0 && cnt_q == C_LOW[`CNT_W-1:0] - 1'b1) begin
            sda_oe_q <= !rd_q;
            sda_o_q <= sh_q[NBITS-1];
          end
        end
        `ST_I2C_STOP: begin
          if (cnt_zero && scl_o_q == 1'b0) begin
            scl_o_q <= 1'b1;
            cnt_q <= C_HIGH[`CNT_W-1:0];
          end else if (cnt_zero) begin
            sda_o_q <= 1'b1;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            cnt_q <= C_BUF[`CNT_W-1:0];
            st_q <= `ST_GAP;
          end
        end
        `ST_SPI_SEL: begin
          if (cnt_zero) begin
            mosi_q <= sh_q[NBITS-1];
            sclk_q <= 1'b1;
            ph_q <= 2'h1;
            cnt_q <= spi_half;
            st_q <= `ST_SPI_BIT;
          end
        end
        `ST_SPI_BIT: begin
          if (cnt_zero) begin
            if (ph_q == 2'h1) begin
              // Falling edge: device samples mosi, readout settled since rise
              sclk_q <= 1'b0;
              sh_q <= {sh_q[NBITS-2:0], miso_sync_q[1]};
              ph_q <= 2'h0;
              cnt_q <= spi_half;
              bit_q <= bit_q - 6'h1;
              if (bit_q == 6'h1) begin
                st_q <= `ST_SPI_END;
              end
            end else begin
              mosi_q <= sh_q[NBITS-1];
              sclk_q <= 1'b1;
              ph_q <= 2'h1;
              cnt_q <= spi_half;
            end
          end
        end
        `ST_SPI_END: begin
          if (cnt_zero) begin
            sync_n_q <= 1'b1;
            cnt_q <= spi_half;
            st_q <= `ST_GAP;
          end
        end
        `ST_GAP: begin
          if (cnt_zero) begin
            rsp_data_q <= sh_q;
            rsp_valid_q <= 1'b1;
            upd_pulse_q <= !rd_q;
            after_frame_q <= 1'b1;
            st_q <= `ST_IDLE;
          end
        end
        `ST_LOAD: begin
          if (cnt_zero) begin
            output_load_strobe_n_q <= 1'b0;
            cnt_q <= C_LDW[`CNT_W-1:0];
            st_q <= `ST_LOAD_HOLD;
          end
        end
        `ST_LOAD_HOLD: begin
          if (cnt_zero) begin
            output_load_strobe_n_q <= 1'b1;
            after_frame_q <= 1'b0;
            rsp_valid_q <= 1'b1;
            st_q <= `ST_IDLE;
          end
        end
        default: begin
          st_q <= `ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: test/host_link_ctrl_monitor.sv */
// Purpose: pin-level checker for host_link_ctrl
// Assumes: 125 MHz ref_clk, phase counts as chosen by the design
// Notes: bound from the bench top file
module host_link_monitor #(
  parameter NCH = 2
) (
  input wire ref_clk,
  input wire rstn,
  input wire req_valid,
  input wire req_ready,
  input wire req_read,
  input wire req_bcast,
  input wire req_load,
  input wire [NCH-1:0] req_chan,
  input wire fast_readout_select,
  input wire rsp_valid_q,
  input wire scl_o_q,
  input wire sda_o_q,
  input wire sda_oe_q,
  input wire sclk_q,
  input wire sync_n_q,
  input wire output_load_strobe_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  bit sda_p, sn_p, rd_q, fs_q, wr_q;
  bit [NCH-1:0] ch_q, lch_q;
  int lo_n, hi_n, st_n, sk_n, ld_n, sh_n, f_n, w_n;
  wire sda_d = !sda_oe_q | sda_o_q;
  wire [NCH-1:0] cm = req_bcast ? {NCH{1'b1}} : req_chan;
  wire upd = req_valid && req_ready && !req_read && !req_load && |(cm & lch_q);
  // ----------------
  // Phase counters
  // ----------------
  always @(posedge ref_clk) begin
    sda_p <= sda_d;
    sn_p <= sync_n_q;
    lo_n <= scl_o_q ? 0 : lo_n + 1;
    hi_n <= scl_o_q ? hi_n + 1 : 0;
    st_n <= (sda_p && !sda_d && scl_o_q) ? 0 : st_n + 1;
    sk_n <= sclk_q ? sk_n + 1 : 0;
    ld_n <= output_load_strobe_n_q ? 0 : ld_n + 1;
    if (req_valid && req_ready) begin
      rd_q <= req_read;
      fs_q <= fast_readout_select;
      wr_q <= !req_read && !req_load;
      ch_q <= cm;
    end
  end
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sh_n <= 1000;
      f_n <= 1000;
      w_n <= 1000;
      lch_q <= '0;
    end else begin
      sh_n <= sda_d ? sh_n + 1 : 0;
      f_n <= ((!sda_p && sda_d && scl_o_q) || (!sn_p && sync_n_q)) ? 0 : f_n + 1;
      w_n <= (rsp_valid_q && wr_q) ? 0 : w_n + 1;
      if (rsp_valid_q && wr_q) lch_q <= ch_q;
    end
  end
  // ----------------
  // Properties
  // ----------------
  sequence scl_dn_s;
    $fell(scl_o_q);
  endsequence
  sequence sclk_dn_s;
    $fell(sclk_q);
  endsequence
  sequence start_s;
    $fell(sda_d) && scl_o_q;
  endsequence
  bus_free_a: assert property (start_s |-> sh_n >= 63)
    else $error("bus free time short");
  start_hold_a: assert property (scl_dn_s |-> st_n >= 32)
    else $error("start hold short");
  scl_low_a: assert property ($rose(scl_o_q) |-> lo_n >= 63)
    else $error("scl low phase short");
  scl_high_a: assert property (scl_dn_s |-> hi_n >= 33)
    else $error("scl high phase short");
  wr_clk_a: assert property (sclk_dn_s |-> sk_n >= 2)
    else $error("sclk high phase short");
  rd_clk_a: assert property (sclk_dn_s and rd_q |-> sk_n >= (fs_q ? 22 : 44))
    else $error("read sclk too fast");
  upd_wait_a: assert property (upd |-> w_n >= 249)
    else $error("update spacing short");
  load_width_a: assert property ($rose(output_load_strobe_n_q) |-> ld_n >= 250)
    else $error("load strobe too short");
  load_gap_a: assert property ($fell(output_load_strobe_n_q) |-> f_n >= 124)
    else $error("load strobe too soon");
endmodule

/* File: test/host_dev_model.sv */
// Purpose: behavioural converter device on the far side of the link
// Assumes: readout data changes 100 ns after sclk rise
// Notes: por_n stands in for power-on
module host_dev_model #(
  parameter logic [31:0] RD_PAT = 32'hc3a5_96e1,
  parameter bit SDO_EN = 1'b1
) (
  input wire por_n,
  input wire sclk,
  input wire mosi,
  input wire sync_n,
  input wire scl,
  input wire sda,
  input wire load_n,
  output wire miso,
  output logic [31:0] word_q,
  output logic [31:0] dac_q
);
  timeunit 1ns;
  timeprecision 1ps;
  bit [1:0] lock;
  bit bit_r;
  logic [31:0] sh;
  logic [5:0] idx;
  wire spi_ok = lock != 2'h1;
  always @(negedge sync_n or negedge sda or negedge por_n) begin
    if (!por_n) lock <= 2'h0;
    else if (lock == 2'h0) lock <= !sync_n ? 2'h2 : (scl ? 2'h1 : 2'h0);
  end
  always @(posedge sclk or negedge sync_n) begin
    if (!sclk) idx <= 6'h0;
    else if (spi_ok) begin
      bit_r <= #100 RD_PAT[5'h1f - idx[4:0]];
      idx <= idx + 6'h1;
    end
  end
  assign miso = (SDO_EN && !sync_n) ? bit_r : ~bit_r;
  always @(negedge sclk) if (!sync_n) sh <= {sh[30:0], mosi};
  always @(posedge sync_n) if (spi_ok && por_n) word_q <= sh;
  always @(negedge load_n) dac_q <= #1000 word_q;
endmodule

/* File: test/tb_host_link_ctrl.sv */
// Purpose: self-checking bench for host_link_ctrl
// Assumes: device model on the far side, 125 MHz ref_clk
// Notes: second reset between the I2C and SPI parts
module tb_host_link_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT = 32'hc3a5_96e1;
  logic ref_clk = 0, rstn = 0, req_valid = 0, req_proto = 0, req_read = 0;
  logic req_bcast = 0, req_load = 0, fast_readout_select = 0;
  logic [1:0] req_chan = 2'h1;
  logic [5:0] req_len = 6'h1;
  logic [31:0] req_data = 32'h0, r;
  wire req_ready, rsp_valid_q, scl_o_q, scl_oe_q, sda_o_q, sda_oe_q, miso;
  wire sclk_q, mosi_q, sync_n_q, output_load_strobe_n_q;
  wire [31:0] rsp_data_q, word_q, dac_q;
  wire sda_i = !(sda_oe_q && !sda_o_q);
  wire scl_w = !(scl_oe_q && !scl_o_q);
  logic [65:0] exp_q[$];
  logic [65:0] e;
  string nm[3] = '{"rsp_data_q", "word_q", "dac_q"};
  int miscompares = 0, check_count = 0;
  always #4 ref_clk = ~ref_clk;
  host_link_ctrl #(.NBITS(32), .NCH(2)) u_host_link_ctrl (.ref_clk, .rstn, .req_valid,
    .req_ready, .req_proto, .req_read, .req_bcast, .req_load, .req_chan, .req_len, .req_data,
    .fast_readout_select, .rsp_data_q, .rsp_valid_q, .scl_o_q, .scl_oe_q, .sda_i, .sda_o_q,
    .sda_oe_q, .sclk_q, .mosi_q, .sync_n_q, .miso, .output_load_strobe_n_q);
  host_dev_model #(.RD_PAT(PAT)) u_host_dev_model (.por_n(rstn), .sclk(sclk_q),
    .mosi(mosi_q), .sync_n(sync_n_q), .scl(scl_w), .sda(sda_i),
    .load_n(output_load_strobe_n_q), .miso, .word_q, .dac_q);
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic send(input logic [3:0] f, input logic [1:0] c, input logic [5:0] n,
      input logic [31:0] d, input logic [65:0] x);
    int i;
    exp_q.push_back(x);
    @(posedge ref_clk);
    {req_proto, req_read, req_bcast, req_load} <= f;
    req_chan <= c;
    req_len <= n;
    req_data <= d;
    req_valid <= 1'b1;
    @(negedge ref_clk);
    for (i = 0; i < 9000 && req_ready !== 1'b1; i++) @(negedge ref_clk);
    if (i == 9000) begin
      miscompares++;
      $display("Error req_ready expected 1 seen 0");
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask
  task automatic drain(input string t);
    for (int i = 0; i < 9000 && exp_q.size() > 0; i++) @(posedge ref_clk);
    if (exp_q.size() > 0) begin
      miscompares++;
      $display("Error exp_q expected 0 seen %0d", exp_q.size());
      exp_q.delete();
    end
    $display("Test %s done", t);
  endtask
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic close_out;
    $display("Checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------
  // Result watcher
  // ----------------
  always @(negedge ref_clk) if (rsp_valid_q === 1'b1) begin
    if (exp_q.size() == 0) chk("queue", 32'h0, 32'h1);
    else begin
      e = exp_q.pop_front();
      chk(nm[e[65:64]], e[31:0] & e[63:32],
        (e[65] ? dac_q : (e[64] ? word_q : rsp_data_q)) & e[63:32]);
    end
  end
  // ----------------
  // Sequence
  // ----------------
  initial begin
    void'($urandom(32'h6341a9d0));
    do_reset();
    r = $urandom();
    send(4'h0, 2'h1, 6'd16, {r[15:0], 16'h0}, {2'h0, 32'hffff, 16'h0, r[15:0]});
    send(4'h0, 2'h2, 6'd16, {r[31:16], 16'h0}, {2'h0, 32'hffff, 16'h0, r[31:16]});
    send(4'h4, 2'h1, 6'd8, 32'h0, {34'hff, 32'hff});
    send(4'h1, 2'h1, 6'd1, 32'h0, {2'h0, 32'hffffffff, 32'hff});
    drain("i2c");
    @(posedge ref_clk);
    {req_proto, req_read, req_bcast, req_load, req_valid} <= 5'h11;
    repeat (20) @(negedge ref_clk);
    chk("req_ready", 32'h0, {31'h0, req_ready});
    $display("Test protocol lock done");
    @(posedge ref_clk);
    req_valid <= 1'b0;
    do_reset();
    r = $urandom();
    send(4'h8, 2'h1, 6'd32, r, {2'h1, 32'hffffffff, r});
    send(4'h8, 2'h1, 6'd32, ~r, {2'h1, 32'hffffffff, ~r});
    send(4'ha, 2'h3, 6'd32, r ^ 32'h5a5a, {2'h1, 32'hffffffff, r ^ 32'h5a5a});
    send(4'h8, 2'h2, 6'd32, r, {2'h1, 32'hffffffff, r});
    send(4'h9, 2'h1, 6'd1, 32'h0, {2'h2, 32'hffffffff, r});
    drain("spi write and load");
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      fast_readout_select <= k[0];
      send(4'hc, 2'h1, 6'd8, 32'h0, {34'hff, 24'h0, PAT[31:24]});
      drain("spi read");
    end
    close_out();
  end
  initial begin
    #400us;
    miscompares++;
    close_out();
  end
endmodule
bind host_link_ctrl host_link_monitor #(.NCH(NCH)) u_host_link_monitor (.ref_clk, .rstn,
  .req_valid, .req_ready, .req_read, .req_bcast, .req_load, .req_chan, .fast_readout_select,
  .rsp_valid_q, .scl_o_q, .sda_o_q, .sda_oe_q, .sclk_q, .sync_n_q, .output_load_strobe_n_q);
